// ---- i2c_control_port_input_enable_tb_top.sv ----
`timescale 1ns/1ps

module i2c_control_port_input_enable_tb_top;
  logic        aclk, aresetn, link_clk, link_resetn;
  logic [1:0]  addr_strap_low, addr_strap_high, pins;
  logic        ref_a_enable_pin, ref_b_enable_pin, ref_input_a_en, ref_input_b_en, spi_port_select;
  logic [3:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp;
  logic [33:0] exp_q[$], msk_q[$], e, m;
  logic [7:0]  v, last5;
  logic [6:0]  slv;
  logic [2:0]  code;
  integer      seed;
  int          errors, check_count, cycles;

  icp_link_if link_if();
  icp_host i_icp_host(.aclk, .aresetn, .link(link_if), .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  icp_dev i_icp_dev(.link_clk, .link_resetn, .link(link_if), .addr_strap_low, .addr_strap_high, .ref_a_enable_pin,
    .ref_b_enable_pin, .ref_input_a_en, .ref_input_b_en, .spi_port_select);
  icp_link_assertions i_chk(.aclk, .aresetn, .link_clk, .link_resetn, .scl(link_if.scl),
    .host_sda_o(link_if.host_sda_o), .host_sda_oe_n(link_if.host_sda_oe_n), .dev_sda_o(link_if.dev_sda_o),
    .dev_sda_oe_n(link_if.dev_sda_oe_n), .sda(link_if.sda));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #7.5 link_clk = ~link_clk;
  end

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge aclk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      if (m != 34'h0) check("bus answer", (bvalid ? {bresp, 32'h0} : {rresp, rdata}) & m, e);
    end
  end

  // A hang anywhere ends the run here with a counted mismatch.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] dat, input logic [1:0] er);
    logic aw, w;
    exp_q.push_back({er, 32'h0});
    msk_q.push_back({2'h3, 32'h0});
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [33:0] ex, input logic [33:0] mk);
    exp_q.push_back(ex);
    msk_q.push_back(mk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
  endtask

  task automatic cmd(input logic rd, input logic [7:0] idx, input logic [7:0] dat, input logic [6:0] a);
    axi_wr(4'h0, {8'h0, dat, idx, rd, a}, 2'h0);
    do axi_rd(4'h4, 34'h0, 34'h0); while (d[0] !== 1'b0);
  endtask

  task automatic stat(input logic nack, input logic [7:0] rxd, input logic [7:0] rxm);
    axi_rd(4'h4, {18'h0, rxd & rxm, 6'h0, nack, 1'b0}, {18'h3, rxm, 8'h02});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h4aeaa838;
    {errors, check_count, cycles} = '0;
    {aresetn, link_resetn, awvalid, wvalid, arvalid} = '0;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata} = '0;
    code = 3'($unsigned($random(seed)));
    addr_strap_low = 2'(code / 3);
    addr_strap_high = 2'(code % 3);
    slv = {4'hD, code};
    {ref_b_enable_pin, ref_a_enable_pin} = 2'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    link_resetn <= 1'b1;
    repeat (4) @(posedge aclk);
    for (int f = 0; f < 8; f++) begin
      v = 8'($random(seed));
      v[3:2] = f[1:0];
      pins = 2'($random(seed));
      {ref_b_enable_pin, ref_a_enable_pin} <= pins;
      cmd(1'b0, 8'h05, v, slv);
      stat(1'b0, 8'h00, 8'h00);
      check("input enables", {ref_input_b_en, ref_input_a_en}, (v[3:2] == 2'h0) ? pins : v[3:2]);
      cmd(1'b1, 8'h05, 8'h00, slv);
      stat(1'b0, v, 8'hFF);
      last5 = v;
    end
    v = 8'($random(seed));
    cmd(1'b0, 8'h08, v, slv);
    cmd(1'b1, 8'h08, 8'h00, slv);
    stat(1'b0, v, 8'hFF);
    cmd(1'b0, 8'h09, 8'h5A, slv);
    cmd(1'b1, 8'h09, 8'h00, slv);
    stat(1'b0, 8'h00, 8'hFF);
    cmd(1'b0, 8'h05, ~last5, slv ^ 7'h08);
    stat(1'b1, 8'h00, 8'h00);
    cmd(1'b1, 8'h05, 8'h00, slv);
    stat(1'b0, last5, 8'hFF);
    axi_rd(4'h0, {2'h0, 8'h00, 8'h00, 8'h05, 1'b1, slv}, {2'h3, 32'hFFFFFFFF});
    axi_rd(4'h8, {2'h2, 32'h0}, {2'h3, 32'hFFFFFFFF});
    axi_wr(4'hC, 32'h0, 2'h2);
    addr_strap_low <= 2'h2;
    addr_strap_high <= 2'h2;
    repeat (8) @(posedge aclk);
    check("serial port select", spi_port_select, 1'b1);
    cmd(1'b0, 8'h05, 8'h00, 7'h68);
    stat(1'b1, 8'h00, 8'h00);
    addr_strap_low <= 2'(code / 3);
    addr_strap_high <= 2'(code % 3);
    repeat (8) @(posedge aclk);
    check("serial port select", spi_port_select, 1'b0);
    test_done();
  end
endmodule // i2c_control_port_input_enable_tb_top

// ---- icp_dev.sv ----
// Behaviour
// - Both straps high selects four-wire port instead.
// - Slave only; serial clock is input only.
// - Data line driven low only, else released.
// - Address upper four bits fixed at 1101.
// - Lower address bits come from two straps.
// - Both lines released high outside a session.
// - Master opens session with a start condition.
// - Master closes session with a stop condition.
// - Master makes every clock and transfer.
// - One bit per clock; many bytes per session.
// - Seven address bits, then direction bit.
// - Ninth bit acknowledges address; low means success.
// - Write: register byte follows, acknowledged at bit 18.
// - Store data byte, then advance register pointer.
// - Read returns bytes from pointer to last register.
// - Master leaves last read byte unacknowledged.
// - Enable field decodes pins or fixed enables.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps

`include "icp_map.svh"

module icp_dev
  import icp_pkg::*;
(
  input  wire logic       link_clk,
  input  wire logic       link_resetn,
  icp_link_if.dev         link,
  input  wire logic [1:0] addr_strap_low,
  input  wire logic [1:0] addr_strap_high,
  input  wire logic       ref_a_enable_pin,
  input  wire logic       ref_b_enable_pin,
  output logic            ref_input_a_en,
  output logic            ref_input_b_en,
  output logic            spi_port_select
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [2:0] addr_low(input logic [1:0] lo, input logic [1:0] hi);
    logic [2:0] a;
    a = {1'b0, lo};
    return 3'((a << 1) + a + {1'b0, hi});
  endfunction

  function automatic logic [1:0] en_decode(input logic [1:0] field, input logic pa, input logic pb);
    logic [1:0] r;
    r = 2'h0;
    case (field)
      `ICP_EN_PINS:   r = {pb, pa};
      `ICP_EN_ONLY_A: r = 2'h1;
      `ICP_EN_ONLY_B: r = 2'h2;
      default:        r = 2'h3;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] reg_read(input logic [8:0][7:0] regs, input logic [7:0] p);
    logic [7:0] r;
    r = `ICP_REG_RST;
    if (p <= `ICP_LAST_REG) begin
      r = regs[p[3:0]];
    end
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  icp_dev_t s;
  icp_dev_t next_s;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic [1:0] ens;
  logic [7:0] rbyte;

  always_comb begin
    next_s = s;
    // Pins come from outside this domain and pass two flops before use.
    next_s.scl_m   = link.scl;
    next_s.scl_s   = s.scl_m;
    next_s.scl_d   = s.scl_s;
    next_s.sda_m   = link.sda;
    next_s.sda_s   = s.sda_m;
    next_s.sda_d   = s.sda_s;
    next_s.strap_m = {addr_strap_high, addr_strap_low};
    next_s.strap_s = s.strap_m;
    next_s.sel_m   = {ref_b_enable_pin, ref_a_enable_pin};
    next_s.sel_s   = s.sel_m;

    next_s.spi_mode = (s.strap_s[1:0] == `ICP_STRAP_HIGH) && (s.strap_s[3:2] == `ICP_STRAP_HIGH);

    ens = en_decode(s.regs[`ICP_EN_REG][`ICP_EN_FIELD_HI:`ICP_EN_FIELD_LO], s.sel_s[0], s.sel_s[1]);
    next_s.en_a = ens[0];
    next_s.en_b = ens[1];

    // Clock is sampled only; no edge of it is ever driven from here.
    scl_rise   = s.scl_s && !s.scl_d;
    scl_fall   = !s.scl_s && s.scl_d;
    start_seen = s.scl_s && s.scl_d && s.sda_d && !s.sda_s;
    stop_seen  = s.scl_s && s.scl_d && !s.sda_d && s.sda_s;
    rbyte      = reg_read(s.regs, s.ptr);

    if (scl_rise) begin
      case (s.st)
        ICP_D_ADDR, ICP_D_REG, ICP_D_WDATA: begin
          next_s.shreg  = {s.shreg[6:0], s.sda_s};
          next_s.bitcnt = s.bitcnt + 4'h1;
        end
        default: begin
        end
      endcase
    end

    if (stop_seen || s.spi_mode) begin
      next_s.st    = ICP_D_IDLE;
      next_s.drive = 1'b0;
    end else if (start_seen) begin
      next_s.st     = ICP_D_ADDR;
      next_s.bitcnt = 4'h0;
      next_s.drive  = 1'b0;
    end else begin
      case (s.st)
        ICP_D_IDLE: begin
          next_s.drive = 1'b0;
        end
        ICP_D_ADDR: begin
          if (scl_fall && s.bitcnt == `ICP_BITS_PER_BYTE) begin
            // Address sits in the first seven bits, direction in the eighth.
            if (s.shreg[7:1] == {`ICP_ADDR_FIXED, addr_low(s.strap_s[1:0], s.strap_s[3:2])}) begin
              next_s.rw    = s.shreg[0];
              next_s.drive = 1'b1;
              next_s.st    = ICP_D_ADDR_ACK;
            end else begin
              next_s.st = ICP_D_IDLE;
            end
          end
        end
        ICP_D_ADDR_ACK: begin
          if (scl_fall) begin
            next_s.bitcnt = 4'h0;
            if (s.rw == `ICP_READ_BIT) begin
              next_s.shreg = rbyte;
              next_s.drive = !rbyte[7];
              next_s.st    = ICP_D_RDATA;
            end else begin
              next_s.drive = 1'b0;
              next_s.st    = ICP_D_REG;
            end
          end
        end
        ICP_D_REG: begin
          if (scl_fall && s.bitcnt == `ICP_BITS_PER_BYTE) begin
            next_s.ptr   = s.shreg;
            next_s.drive = 1'b1;
            next_s.st    = ICP_D_REG_ACK;
          end
        end
        ICP_D_REG_ACK, ICP_D_WACK: begin
          if (scl_fall) begin
            next_s.drive  = 1'b0;
            next_s.bitcnt = 4'h0;
            next_s.st     = ICP_D_WDATA;
          end
        end
        ICP_D_WDATA: begin
          if (scl_fall && s.bitcnt == `ICP_BITS_PER_BYTE) begin
            // Writes past the last register are acknowledged but dropped.
            if (s.ptr <= `ICP_LAST_REG) begin
              next_s.regs[s.ptr[3:0]] = s.shreg;
            end
            next_s.ptr   = s.ptr + 8'h01;
            next_s.drive = 1'b1;
            next_s.st    = ICP_D_WACK;
          end
        end
        ICP_D_RDATA: begin
          if (scl_fall) begin
            if (s.bitcnt == `ICP_BITS_PER_BYTE - 4'h1) begin
              next_s.drive = 1'b0;
              next_s.st    = ICP_D_RACK;
            end else begin
              next_s.bitcnt = s.bitcnt + 4'h1;
              next_s.shreg  = {s.shreg[6:0], 1'b0};
              next_s.drive  = !s.shreg[6];
            end
          end
        end
        ICP_D_RACK: begin
          if (scl_rise) begin
            if (s.sda_s) begin
              next_s.st = ICP_D_IDLE;
            end else begin
              // The pointer stops at the last register so longer reads repeat it.
              if (s.ptr < `ICP_LAST_REG) begin
                next_s.ptr = s.ptr + 8'h01;
              end
              next_s.st = ICP_D_RLOAD;
            end
          end
        end
        ICP_D_RLOAD: begin
          if (scl_fall) begin
            next_s.bitcnt = 4'h0;
            next_s.shreg  = rbyte;
            next_s.drive  = !rbyte[7];
            next_s.st     = ICP_D_RDATA;
          end
        end
        default: begin
          next_s.st    = ICP_D_IDLE;
          next_s.drive = 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    if (!link_resetn) begin
      s <= '0;
      // Line samplers start at the idle-high level so that no false edge follows reset.
      s.scl_m <= 1'b1;
      s.scl_s <= 1'b1;
      s.scl_d <= 1'b1;
      s.sda_m <= 1'b1;
      s.sda_s <= 1'b1;
      s.sda_d <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Open drain: the pad level is always low and only the enable toggles.
  assign link.dev_sda_o    = 1'b0;
  assign link.dev_sda_oe_n = !s.drive;
  assign ref_input_a_en    = s.en_a;
  assign ref_input_b_en    = s.en_b;
  assign spi_port_select   = s.spi_mode;

endmodule // icp_dev

// ---- icp_host.sv ----
`timescale 1ns/1ps

`include "icp_map.svh"

module icp_host
  import icp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  icp_link_if.host         link,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic ofs_ok(input logic [3:0] a);
    return (a == `ICP_CMD_OFS) || (a == `ICP_STAT_OFS);
  endfunction

  icp_host_t s;
  icp_host_t next_s;
  logic      step;
  logic      do_wr;

  always_comb begin
    next_s       = s;
    next_s.sda_m = link.sda;
    next_s.sda_s = s.sda_m;
    do_wr        = 1'b0;

    // ------------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------------
    if (awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = wdata;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (next_s.aw_got && next_s.w_got && !s.bvalid) begin
      do_wr         = 1'b1;
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = ofs_ok(next_s.awaddr) ? `ICP_RESP_OKAY : `ICP_RESP_SLVERR;
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = ofs_ok(araddr) ? `ICP_RESP_OKAY : `ICP_RESP_SLVERR;
      next_s.rdata  = 32'h0000_0000;
      if (araddr == `ICP_CMD_OFS) begin
        next_s.rdata = {8'h00, s.wdat, s.rga, s.rd, s.slv};
      end else if (araddr == `ICP_STAT_OFS) begin
        next_s.rdata = {16'h0000, s.rxd, 6'h00, s.nack, s.busy};
      end
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready  = !next_s.w_got && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;

    // ------------------------------------------------------------------------
    // Bit engine: four quarters per serial clock period
    // ------------------------------------------------------------------------
    step = (s.tick == 4'(`ICP_QUARTER_CYC - 1));
    if (s.st != ICP_H_IDLE) begin
      next_s.tick = step ? 4'h0 : s.tick + 4'h1;
    end
    if (s.st != ICP_H_IDLE && step) begin
      next_s.q = s.q + 2'h1;
      case (s.st)
        ICP_H_START: begin
          case (s.q)
            2'h0: begin
              next_s.scl = 1'b1;
              next_s.rel = 1'b1;
            end
            2'h1: next_s.rel = 1'b0;
            2'h2: next_s.scl = 1'b0;
            default: begin
              next_s.st    = ICP_H_BIT;
              next_s.bitn  = 4'h0;
              next_s.shreg = {s.slv, `ICP_WRITE_BIT};
            end
          endcase
        end
        ICP_H_RSTART: begin
          case (s.q)
            2'h0: next_s.rel = 1'b1;
            2'h1: next_s.scl = 1'b1;
            2'h2: next_s.rel = 1'b0;
            default: begin
              next_s.scl   = 1'b0;
              next_s.st    = ICP_H_BIT;
              next_s.bitn  = 4'h0;
              next_s.shreg = {s.slv, `ICP_READ_BIT};
            end
          endcase
        end
        ICP_H_STOP: begin
          case (s.q)
            2'h0: next_s.rel = 1'b0;
            2'h1: next_s.scl = 1'b1;
            2'h2: next_s.rel = 1'b1;
            default: begin
              next_s.st   = ICP_H_IDLE;
              next_s.busy = 1'b0;
            end
          endcase
        end
        ICP_H_BIT: begin
          case (s.q)
            2'h0: begin
              // Ninth bit and every received bit leave the line released.
              next_s.rel = (s.bitn == `ICP_BITS_PER_BYTE) || (s.stage == 2'h3) || s.shreg[7];
            end
            2'h1: next_s.scl = 1'b1;
            2'h2: begin
              if (s.bitn != `ICP_BITS_PER_BYTE) begin
                next_s.shreg = {s.shreg[6:0], s.sda_s};
              end else if (s.stage != 2'h3) begin
                next_s.nack = s.sda_s;
              end
            end
            default: begin
              next_s.scl  = 1'b0;
              next_s.bitn = s.bitn + 4'h1;
              if (s.bitn == `ICP_BITS_PER_BYTE) begin
                next_s.bitn = 4'h0;
                if (s.stage == 2'h3) begin
                  next_s.rxd = s.shreg;
                  next_s.st  = ICP_H_STOP;
                end else if (s.nack) begin
                  next_s.st = ICP_H_STOP;
                end else if (s.stage == 2'h0) begin
                  next_s.stage = 2'h1;
                  next_s.shreg = s.rga;
                end else if (s.stage == 2'h1) begin
                  next_s.stage = 2'h2;
                  next_s.shreg = s.wdat;
                  if (s.rd) begin
                    next_s.st = ICP_H_RSTART;
                  end
                end else if (s.rd) begin
                  next_s.stage = 2'h3;
                  next_s.shreg = 8'h00;
                end else begin
                  next_s.st = ICP_H_STOP;
                end
              end
            end
          endcase
        end
        default: next_s.st = ICP_H_IDLE;
      endcase
    end

    // A command arriving while a transfer runs is answered but ignored.
    if (do_wr && next_s.awaddr == `ICP_CMD_OFS && !s.busy) begin
      {next_s.wdat, next_s.rga, next_s.rd, next_s.slv} = next_s.wdata[23:0];
      next_s.busy  = 1'b1;
      next_s.nack  = 1'b0;
      next_s.st    = ICP_H_START;
      next_s.q     = 2'h0;
      next_s.tick  = 4'h0;
      next_s.stage = 2'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s     <= '0;
      s.scl <= 1'b1;
      s.rel <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign link.scl           = s.scl;
  assign link.host_sda_o    = 1'b0;
  assign link.host_sda_oe_n = s.rel;
  assign awready            = s.awready;
  assign wready             = s.wready;
  assign bvalid             = s.bvalid;
  assign bresp              = s.bresp;
  assign arready            = s.arready;
  assign rvalid             = s.rvalid;
  assign rdata              = s.rdata;
  assign rresp              = s.rresp;

endmodule // icp_host

// ---- icp_link_assertions.sv ----
`timescale 1ns/1ps

module icp_link_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic link_clk,
  input wire logic link_resetn,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic sda
);
  // ----------------------------------------------------------------
  // Wire rules
  // ----------------------------------------------------------------
  a_drivers_low_only: assert property (@(posedge aclk) disable iff (!aresetn)
    !host_sda_o && !dev_sda_o) else $error("a data driver offers a high level");
  a_dev_pull_wins: assert property (@(posedge link_clk) disable iff (!link_resetn)
    !dev_sda_oe_n |-> !sda) else $error("device pull does not bring the data line low");
  a_start_then_clock: assert property (@(posedge aclk) disable iff (!aresetn)
    scl && $fell(sda) |-> ##[1:4] !scl) else $error("start condition not followed by clock");
  a_stop_frees_bus: assert property (@(posedge aclk) disable iff (!aresetn)
    scl && $rose(sda) |=> scl [*6]) else $error("clock moved right after a stop");
  a_clock_high_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(scl) |=> scl [*3]) else $error("clock high phase too short");
  a_clock_low_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(scl) |=> !scl [*3]) else $error("clock low phase too short");
  a_dev_idle_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    scl [*8] |-> dev_sda_oe_n) else $error("device pulls data line while bus is idle");
  // The device resamples the clock, so a change right at a rising clock is not flagged; only later high samples are checked.
  a_dev_steady_high: assert property (@(posedge link_clk) disable iff (!link_resetn)
    scl && $past(scl) |-> $stable(dev_sda_oe_n)) else $error("device data changed while clock high");

  c_start: cover property (@(posedge aclk) disable iff (!aresetn) scl && $fell(sda));
  c_dev_ack: cover property (@(posedge link_clk) disable iff (!link_resetn) $fell(dev_sda_oe_n));
  c_stop: cover property (@(posedge aclk) disable iff (!aresetn) scl && $rose(sda));
endmodule // icp_link_assertions

// ---- icp_link_if.sv ----
`timescale 1ns/1ps

interface icp_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;

  // The pull-up makes a released line read high; any enabled low driver wins.
  assign sda = !((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o));

  modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
  modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface

// ---- icp_map.svh ----
`ifndef ICP_MAP_SVH
`define ICP_MAP_SVH

// ----------------------------------------------------------------------------
// Serial slave address and register space
// ----------------------------------------------------------------------------
`define ICP_ADDR_FIXED     4'hD
`define ICP_LAST_REG       8'h08
`define ICP_REG_RST        8'h00
`define ICP_EN_REG         4'h5
`define ICP_EN_FIELD_HI    3
`define ICP_EN_FIELD_LO    2
`define ICP_EN_PINS        2'h0
`define ICP_EN_ONLY_A      2'h1
`define ICP_EN_ONLY_B      2'h2
`define ICP_EN_BOTH        2'h3
`define ICP_BITS_PER_BYTE  4'h8
`define ICP_READ_BIT       1'h1
`define ICP_WRITE_BIT      1'h0

// ----------------------------------------------------------------------------
// Three-level strap codes
// ----------------------------------------------------------------------------
`define ICP_STRAP_LOW      2'h0
`define ICP_STRAP_OPEN     2'h1
`define ICP_STRAP_HIGH     2'h2

// ----------------------------------------------------------------------------
// Controller registers and timing
// ----------------------------------------------------------------------------
`define ICP_CMD_OFS        4'h0
`define ICP_STAT_OFS       4'h4
`define ICP_STAT_BUSY      0
`define ICP_STAT_NACK      1
`define ICP_STAT_RXD_LO    8
`define ICP_RESP_OKAY      2'h0
`define ICP_RESP_SLVERR    2'h2
`define ICP_ACLK_NS        100
`define ICP_QUARTER_NS     200
`define ICP_QUARTER_CYC    ((`ICP_QUARTER_NS + `ICP_ACLK_NS - 1) / `ICP_ACLK_NS)

`endif

// ---- icp_pkg.sv ----
package icp_pkg;

  typedef enum logic [3:0] {
    ICP_D_IDLE     = 4'h0,
    ICP_D_ADDR     = 4'h1,
    ICP_D_ADDR_ACK = 4'h2,
    ICP_D_REG      = 4'h3,
    ICP_D_REG_ACK  = 4'h4,
    ICP_D_WDATA    = 4'h5,
    ICP_D_WACK     = 4'h6,
    ICP_D_RDATA    = 4'h7,
    ICP_D_RACK     = 4'h8,
    ICP_D_RLOAD    = 4'h9
  } icp_dev_st_t;

  typedef enum logic [2:0] {
    ICP_H_IDLE   = 3'h0,
    ICP_H_START  = 3'h1,
    ICP_H_BIT    = 3'h2,
    ICP_H_RSTART = 3'h3,
    ICP_H_STOP   = 3'h4
  } icp_host_st_t;

  typedef struct packed {
    logic            scl_m;
    logic            scl_s;
    logic            scl_d;
    logic            sda_m;
    logic            sda_s;
    logic            sda_d;
    logic [3:0]      strap_m;
    logic [3:0]      strap_s;
    logic [1:0]      sel_m;
    logic [1:0]      sel_s;
    icp_dev_st_t     st;
    logic [3:0]      bitcnt;
    logic [7:0]      shreg;
    logic            rw;
    logic [7:0]      ptr;
    logic [8:0][7:0] regs;
    logic            drive;
    logic            en_a;
    logic            en_b;
    logic            spi_mode;
  } icp_dev_t;

  typedef struct packed {
    logic         aw_got;
    logic         w_got;
    logic [3:0]   awaddr;
    logic [31:0]  wdata;
    logic         awready;
    logic         wready;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         arready;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic [6:0]   slv;
    logic         rd;
    logic [7:0]   rga;
    logic [7:0]   wdat;
    logic         busy;
    logic         nack;
    logic [7:0]   rxd;
    icp_host_st_t st;
    logic [1:0]   q;
    logic [3:0]   tick;
    logic [3:0]   bitn;
    logic [1:0]   stage;
    logic [7:0]   shreg;
    logic         scl;
    logic         rel;
    logic         sda_m;
    logic         sda_s;
  } icp_host_t;

endpackage
